/* stc_pkg.sv */
// stc_pkg: addresses, field positions, modes and reset values of the split timer
package stc_pkg;
	// ----------------------------------------------------------------
	// special function register addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_TCS     = 8'h88;
	localparam logic [7:0] ADDR_TMR     = 8'h89;
	localparam logic [7:0] ADDR_T0_LOW  = 8'h8A;
	localparam logic [7:0] ADDR_TL1     = 8'h8B;
	localparam logic [7:0] ADDR_T0_HIGH = 8'h8C;
	localparam logic [7:0] ADDR_TH1     = 8'h8D;

	// ----------------------------------------------------------------
	// timer_control_status fields
	// ----------------------------------------------------------------
	localparam int TCS_T1_FLAG = 7;
	localparam int TCS_T1_RUN  = 6;
	localparam int TCS_T0_FLAG = 5;
	localparam int TCS_T0_RUN  = 4;

	// ----------------------------------------------------------------
	// timer_mode_register fields
	// ----------------------------------------------------------------
	localparam int TMR_T1_GATE = 7;
	localparam int TMR_T1_SRC  = 6;
	localparam int TMR_T1_MODE = 4;
	localparam int TMR_T0_GATE = 3;
	localparam int TMR_T0_SRC  = 2;
	localparam int TMR_T0_MODE = 0;

	// ----------------------------------------------------------------
	// mode_select_field encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_13BIT  = 2'h0;
	localparam logic [1:0] MODE_16BIT  = 2'h1;
	localparam logic [1:0] MODE_RELOAD = 2'h2;
	localparam logic [1:0] MODE_SPLIT  = 2'h3;

	// ----------------------------------------------------------------
	// reset values and constants
	// ----------------------------------------------------------------
	localparam logic [7:0]  RST_BYTE   = 8'h00;
	localparam logic [7:0]  BYTE_ONES  = 8'hFF;
	localparam logic [12:0] ONES_13    = 13'h1FFF;
	localparam logic [7:0]  BIT_ONE    = 8'h01;
	localparam logic [3:0]  SYNC_RESET = 4'hF;
endpackage

/* stc_sync_edge.sv */
// stc_sync_edge: two-flop synchronisers with falling edge detect per input
`timescale 1ns/1ps
`default_nettype none
module stc_sync_edge (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       reset,
	// raw pins
	input  wire logic [3:0] async_in,
	// synchronised level and one-cycle falling edge
	output logic      [3:0] level,
	output logic      [3:0] fall
);
	logic [3:0] meta_q;
	logic [3:0] sync_q;
	logic [3:0] prev_q;

	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_bit
			// idle-high pins reset high so release gives no false edge
			always_ff @(posedge clk_sys) begin
				if (reset) begin
					meta_q[i] <= stc_pkg::SYNC_RESET[i];
					sync_q[i] <= stc_pkg::SYNC_RESET[i];
					prev_q[i] <= stc_pkg::SYNC_RESET[i];
				end else begin
					meta_q[i] <= async_in[i];
					sync_q[i] <= meta_q[i];
					prev_q[i] <= sync_q[i];
				end
			end
			assign level[i] = sync_q[i];
			assign fall[i]  = prev_q[i] & ~sync_q[i];
		end
	endgenerate
endmodule
`default_nettype wire

/* stc_timer_top.sv */
// stc_timer_top: paired timers with split mode and the control/status register
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - timer 0 mode 3 splits into two bytes
// - low byte uses timer 0 controls
// - low byte clocks from sysclk or event pin
// - high byte counts system clock only
// - high byte runs on timer 1 run bit
// - high byte overflow sets timer 1 flag
// - timer 1 in mode 3 halts
// - split: timer 1 no external clock, flag
// - timer 1 overflow still gives baud tick
// - control register resets zero, bit addressable
// - run needs gate low or irq high
// - two-bit mode field per timer
module stc_timer_top (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       reset,
	// byte access to special function registers
	input  wire logic       sfr_wr_en,
	input  wire logic       sfr_rd_en,
	input  wire logic [7:0] sfr_addr,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata_q,
	// bit access
	input  wire logic       sfr_bit_wr_en,
	input  wire logic [7:0] sfr_bit_addr,
	input  wire logic       sfr_bit_wdata,
	// interrupt vectoring acknowledges
	input  wire logic       t0_irq_ack,
	input  wire logic       t1_irq_ack,
	// pins
	input  wire logic       t0_event_pin,
	input  wire logic       t1_event_pin,
	input  wire logic       ext_irq0_input,
	input  wire logic       ext_irq1_input,
	// requests and ticks
	output logic            t0_irq_q,
	output logic            t1_irq_q,
	output logic            baud_tick_q
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0] tcs_q, tcs_d, tmr_q, tmr_d;
	logic [7:0] t0_low_count_q, t0_low_count_d;
	logic [7:0] t0_high_count_q, t0_high_count_d;
	logic [7:0] tl1_q, tl1_d, th1_q, th1_d;
	logic [7:0] rdata_d;
	logic       baud_d;
	logic [3:0] pin_lvl, pin_fall;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	stc_sync_edge u_sync (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.async_in ({ext_irq1_input, ext_irq0_input,
		            t1_event_pin, t0_event_pin}),
		.level    (pin_lvl),
		.fall     (pin_fall)
	);

	// ----------------------------------------------------------------
	// count step: returns {overflow, high, low}
	// ----------------------------------------------------------------
	function automatic logic [16:0] tmr_step(input logic [1:0] mode,
		input logic [7:0] lo, input logic [7:0] hi);
		logic [12:0] c13;
		logic [16:0] r;
		c13 = {hi, lo[4:0]} + 13'h0001;
		case (mode)
			stc_pkg::MODE_13BIT: begin
				r = {({hi, lo[4:0]} == stc_pkg::ONES_13), c13[12:5],
				     lo[7:5], c13[4:0]};
			end
			stc_pkg::MODE_16BIT: begin
				r = {1'b0, hi, lo} + 17'h0_0001;
			end
			stc_pkg::MODE_RELOAD: begin
				r = (lo == stc_pkg::BYTE_ONES) ? {1'b1, hi, hi}
				                                : {1'b0, hi, lo + 8'h01};
			end
			default: begin
				r = {(lo == stc_pkg::BYTE_ONES), hi, lo + 8'h01};
			end
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// decode and control
	// ----------------------------------------------------------------
	logic        wr_tcs, wr_tmr, wr_t0_low, wr_t0_high, wr_tl1, wr_th1;
	logic [7:0]  tcs_mask, tcs_val, tcs_sw;
	logic [1:0]  t0_mode, t1_mode;
	logic        t0_split, t0_en, t0_tick, t0_inc, t0_ovf;
	logic        t1_en, t1_tick, t1_inc, t1_ovf, t1_set, t0_high_ovf;
	logic [16:0] t0_step, t1_step;

	always_comb begin
		wr_tcs = 1'b0;
		wr_tmr = 1'b0;
		wr_t0_low = 1'b0;
		wr_t0_high = 1'b0;
		wr_tl1 = 1'b0;
		wr_th1 = 1'b0;
		if (sfr_wr_en && sfr_addr == stc_pkg::ADDR_TCS) begin
			wr_tcs = 1'b1;
		end else if (sfr_wr_en && sfr_addr == stc_pkg::ADDR_TMR) begin
			wr_tmr = 1'b1;
		end else if (sfr_wr_en && sfr_addr == stc_pkg::ADDR_T0_LOW) begin
			wr_t0_low = 1'b1;
		end else if (sfr_wr_en && sfr_addr == stc_pkg::ADDR_T0_HIGH) begin
			wr_t0_high = 1'b1;
		end else if (sfr_wr_en && sfr_addr == stc_pkg::ADDR_TL1) begin
			wr_tl1 = 1'b1;
		end else if (sfr_wr_en && sfr_addr == stc_pkg::ADDR_TH1) begin
			wr_th1 = 1'b1;
		end
		// byte write beats a bit write in the same cycle
		if (wr_tcs) begin
			tcs_mask = stc_pkg::BYTE_ONES;
			tcs_val  = sfr_wdata;
		end else if (sfr_bit_wr_en &&
		             sfr_bit_addr[7:3] == stc_pkg::ADDR_TCS[7:3]) begin
			tcs_mask = stc_pkg::BIT_ONE << sfr_bit_addr[2:0];
			tcs_val  = {8{sfr_bit_wdata}};
		end else begin
			tcs_mask = stc_pkg::RST_BYTE;
			tcs_val  = stc_pkg::RST_BYTE;
		end
		tcs_sw = (tcs_q & ~tcs_mask) | (tcs_val & tcs_mask);

		t0_mode  = tmr_q[stc_pkg::TMR_T0_MODE +: 2];
		t1_mode  = tmr_q[stc_pkg::TMR_T1_MODE +: 2];
		t0_split = (t0_mode == stc_pkg::MODE_SPLIT);
		t0_en    = tcs_q[stc_pkg::TCS_T0_RUN] &
		           (~tmr_q[stc_pkg::TMR_T0_GATE] | pin_lvl[2]);
		t0_tick  = tmr_q[stc_pkg::TMR_T0_SRC] ? pin_fall[0] : 1'b1;
		t0_inc   = t0_en & t0_tick;
		t0_step  = tmr_step(t0_mode, t0_low_count_q, t0_high_count_q);
		t0_ovf   = t0_inc & t0_step[16];
		t0_high_ovf = t0_split & tcs_q[stc_pkg::TCS_T1_RUN] &
			(t0_high_count_q == stc_pkg::BYTE_ONES);

		t1_en    = tcs_q[stc_pkg::TCS_T1_RUN] &
		           (~tmr_q[stc_pkg::TMR_T1_GATE] | pin_lvl[3]);
		// split mode steals the external clock from timer 1
		t1_tick  = (tmr_q[stc_pkg::TMR_T1_SRC] & ~t0_split) ?
		           pin_fall[1] : 1'b1;
		t1_inc   = t1_en & t1_tick &
		           (t1_mode != stc_pkg::MODE_SPLIT);
		t1_step  = tmr_step(t1_mode, tl1_q, th1_q);
		t1_ovf   = t1_inc & t1_step[16];
		t1_set   = t0_split ? t0_high_ovf : t1_ovf;
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		tmr_d = wr_tmr ? sfr_wdata : tmr_q;
		tcs_d = tcs_sw;
		// hardware set wins over software clear and over vector clear
		tcs_d[stc_pkg::TCS_T1_FLAG] = t1_set |
			(tcs_mask[stc_pkg::TCS_T1_FLAG] ? tcs_sw[stc_pkg::TCS_T1_FLAG]
			 : (tcs_q[stc_pkg::TCS_T1_FLAG] & ~t1_irq_ack));
		tcs_d[stc_pkg::TCS_T0_FLAG] = t0_ovf |
			(tcs_mask[stc_pkg::TCS_T0_FLAG] ? tcs_sw[stc_pkg::TCS_T0_FLAG]
			 : (tcs_q[stc_pkg::TCS_T0_FLAG] & ~t0_irq_ack));

		// contents carry over unchanged when the mode field changes
		t0_low_count_d = wr_t0_low ? sfr_wdata
			: (t0_inc ? t0_step[7:0] : t0_low_count_q);
		if (wr_t0_high) begin
			t0_high_count_d = sfr_wdata;
		end else if (t0_split) begin
			// split high byte wraps freely and ignores both gates
			if (tcs_q[stc_pkg::TCS_T1_RUN]) begin
				t0_high_count_d = t0_high_count_q + 8'h01;
			end else begin
				t0_high_count_d = t0_high_count_q;
			end
		end else begin
			t0_high_count_d = t0_inc ? t0_step[15:8]
				: t0_high_count_q;
		end
		tl1_d = wr_tl1 ? sfr_wdata : (t1_inc ? t1_step[7:0] : tl1_q);
		th1_d = wr_th1 ? sfr_wdata : (t1_inc ? t1_step[15:8] : th1_q);
		baud_d = t1_ovf;

		rdata_d = sfr_rdata_q;
		if (sfr_rd_en) begin
			if (sfr_addr == stc_pkg::ADDR_TCS) begin
				rdata_d = tcs_q;
			end else if (sfr_addr == stc_pkg::ADDR_TMR) begin
				rdata_d = tmr_q;
			end else if (sfr_addr == stc_pkg::ADDR_T0_LOW) begin
				rdata_d = t0_low_count_q;
			end else if (sfr_addr == stc_pkg::ADDR_T0_HIGH) begin
				rdata_d = t0_high_count_q;
			end else if (sfr_addr == stc_pkg::ADDR_TL1) begin
				rdata_d = tl1_q;
			end else if (sfr_addr == stc_pkg::ADDR_TH1) begin
				rdata_d = th1_q;
			end else begin
				rdata_d = stc_pkg::RST_BYTE;
			end
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tcs_q           <= stc_pkg::RST_BYTE;
			tmr_q           <= stc_pkg::RST_BYTE;
			t0_low_count_q  <= stc_pkg::RST_BYTE;
			t0_high_count_q <= stc_pkg::RST_BYTE;
			tl1_q           <= stc_pkg::RST_BYTE;
			th1_q           <= stc_pkg::RST_BYTE;
			sfr_rdata_q     <= stc_pkg::RST_BYTE;
			t0_irq_q        <= 1'b0;
			t1_irq_q        <= 1'b0;
			baud_tick_q     <= 1'b0;
		end else begin
			tcs_q           <= tcs_d;
			tmr_q           <= tmr_d;
			t0_low_count_q  <= t0_low_count_d;
			t0_high_count_q <= t0_high_count_d;
			tl1_q           <= tl1_d;
			th1_q           <= th1_d;
			sfr_rdata_q     <= rdata_d;
			t0_irq_q        <= tcs_d[stc_pkg::TCS_T0_FLAG];
			t1_irq_q        <= tcs_d[stc_pkg::TCS_T1_FLAG];
			baud_tick_q     <= baud_d;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_low_wrap;
		t0_split && t0_inc && t0_low_count_q == stc_pkg::BYTE_ONES &&
		!wr_t0_low;
	endsequence
	sequence s_high_wrap;
		t0_split && tcs_q[stc_pkg::TCS_T1_RUN] &&
		t0_high_count_q == stc_pkg::BYTE_ONES && !wr_t0_high;
	endsequence

	AST_LOW_WRAP: assert property (s_low_wrap |=>
		t0_low_count_q == 8'h00 && tcs_q[stc_pkg::TCS_T0_FLAG] && t0_irq_q)
		else $error("low byte did not wrap and flag");
	AST_HIGH_SETS_T1: assert property (s_high_wrap |=>
		t0_high_count_q == 8'h00 && tcs_q[stc_pkg::TCS_T1_FLAG] && t1_irq_q)
		else $error("high byte overflow missed timer 1 flag");
	AST_HIGH_COUNTS: assert property (t0_split && !wr_t0_high &&
		tcs_q[stc_pkg::TCS_T1_RUN] |=>
		t0_high_count_q == $past(t0_high_count_q) + 8'h01)
		else $error("high byte did not count system clock");
	AST_HIGH_HOLDS: assert property (t0_split && !wr_t0_high &&
		!tcs_q[stc_pkg::TCS_T1_RUN] |=> $stable(t0_high_count_q))
		else $error("high byte moved without timer 1 run");
	AST_T1_M3_HALT: assert property (t1_mode == stc_pkg::MODE_SPLIT &&
		!wr_tl1 && !wr_th1 |=> $stable(tl1_q) && $stable(th1_q))
		else $error("timer 1 counted in its mode 3");
	AST_T1_NO_FLAG: assert property (t0_split && !t0_high_ovf &&
		tcs_mask[stc_pkg::TCS_T1_FLAG] == 1'b0 |=> !$rose(t1_irq_q))
		else $error("timer 1 raised flag in split mode");
	AST_BAUD: assert property (t1_ovf |=> baud_tick_q)
		else $error("timer 1 overflow gave no baud tick");
	AST_GATE_HOLD: assert property (tmr_q[stc_pkg::TMR_T0_GATE] &&
		!pin_lvl[2] && !wr_t0_low |=> $stable(t0_low_count_q))
		else $error("gated low byte counted");
	AST_ACK_CLEAR: assert property (t1_irq_ack && !t1_set &&
		!tcs_mask[stc_pkg::TCS_T1_FLAG] |=> !t1_irq_q)
		else $error("vector did not clear timer 1 flag");
endmodule
`default_nettype wire

/* stc_event_src.sv */
// stc_event_src: behavioural driver of the event pin and the gating input
`timescale 1ns/1ps
`default_nettype none
module stc_event_src (
	// clock
	input  wire logic clk_sys,
	// requests from the bench
	input  wire logic fire,
	input  wire logic gate_lvl,
	// pins toward the timer
	output logic      event_pin,
	output logic      gate_pin
);
	int cnt = 0;

	// ----------------------------------------------------------------
	// one falling edge per request
	// ----------------------------------------------------------------
	// low for four cycles so the two-flop synchroniser cannot miss it
	always @(posedge clk_sys) begin
		if (fire && cnt == 0)
			cnt <= 8;
		else if (cnt > 0)
			cnt <= cnt - 1;
	end
	assign event_pin = !(cnt > 4);
	assign gate_pin  = gate_lvl;
endmodule
`default_nettype wire

/* testbench.sv */
// testbench: split timer bench against an integer model
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic       clk_sys = 1'b0;
	logic       reset = 1'b1;
	logic       wr = 1'b0, rd = 1'b0, bwr = 1'b0, bdat = 1'b0;
	logic       ack0 = 1'b0, ack1 = 1'b0, fire = 1'b0, gate_lvl = 1'b0;
	logic [7:0] addr = 8'h00, wdat = 8'h00, baddr = 8'h00, rdat, v;
	logic       ev_pin, gate_pin, irq0, irq1, baud;
	int         fails = 0, n_tests = 0, seed = 32'h5e94, bauds = 0;
	int         s, w, m, k, b, ov;

	stc_timer_top i_stc_timer_top (.clk_sys(clk_sys), .reset(reset),
		.sfr_wr_en(wr), .sfr_rd_en(rd), .sfr_addr(addr),
		.sfr_wdata(wdat), .sfr_rdata_q(rdat), .sfr_bit_wr_en(bwr),
		.sfr_bit_addr(baddr), .sfr_bit_wdata(bdat), .t0_irq_ack(ack0),
		.t1_irq_ack(ack1), .t0_event_pin(ev_pin), .t1_event_pin(1'b1),
		.ext_irq0_input(gate_pin), .ext_irq1_input(1'b1),
		.t0_irq_q(irq0), .t1_irq_q(irq1), .baud_tick_q(baud));
	stc_event_src i_stc_event_src (.clk_sys(clk_sys), .fire(fire),
		.gate_lvl(gate_lvl), .event_pin(ev_pin), .gate_pin(gate_pin));

	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (baud === 1'b1) bauds <= bauds + 1;

	// ----------------------------------------------------------------
	// bus tasks and comparison
	// ----------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrb(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		wr <= 1'b1;
		addr <= a;
		wdat <= d;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask
	task automatic bw(input logic [7:0] a, input logic d);
		@(posedge clk_sys);
		bwr <= 1'b1;
		baddr <= a;
		bdat <= d;
		@(posedge clk_sys);
		bwr <= 1'b0;
	endtask
	task automatic rdb(input logic [7:0] a);
		@(posedge clk_sys);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_sys);
		rd <= 1'b0;
		@(negedge clk_sys);
		v = rdat;
	endtask
	task automatic ackp(input int i);
		@(posedge clk_sys);
		if (i == 1)
			ack1 <= 1'b1;
		else
			ack0 <= 1'b1;
		@(posedge clk_sys);
		ack0 <= 1'b0;
		ack1 <= 1'b0;
		@(negedge clk_sys);
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		results();
	end

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk_sys);
		reset <= 1'b0;
		rdb(8'h88); check(v, 8'h00);
		rdb(8'h89); check(v, 8'h00);
		rdb(8'h90); check(v, 8'h00);
		$display("test reset done");
		// one half runs, the model counts w+2 edges and any wrap
		wrb(8'h89, 8'h03);
		for (k = 0; k < 6; k++) begin
			s = $random(seed);
			s = s & 255;
			w = $random(seed);
			w = w & 31;
			m = k % 2;
			wrb(8'h88, 8'h00);
			wrb(8'h8A, 8'h00);
			wrb(8'h8C, 8'h00);
			wrb(m ? 8'h8C : 8'h8A, s[7:0]);
			wrb(8'h88, m ? 8'h40 : 8'h10);
			repeat (w) @(posedge clk_sys);
			bw(m ? 8'h8E : 8'h8C, 1'b0);
			s = s + w + 2;
			rdb(8'h8A); check(v, m ? 8'h00 : s[7:0]);
			rdb(8'h8C); check(v, m ? s[7:0] : 8'h00);
			b = (s > 255) ? (m ? 8'h80 : 8'h20) : 8'h00;
			rdb(8'h88); check(v, b[7:0]);
			check({irq1, irq0}, {b[7], b[5]});
		end
		$display("test split counting done");
		// both flags up, cleared one by one on vectoring
		wrb(8'h8A, 8'hFF);
		wrb(8'h8C, 8'hFF);
		wrb(8'h88, 8'h50);
		bw(8'h8E, 1'b0);
		bw(8'h8C, 1'b0);
		rdb(8'h88); check(v, 8'hA0);
		ackp(0); check({irq1, irq0}, 2'b10);
		ackp(1); check({irq1, irq0}, 2'b00);
		rdb(8'h88); check(v, 8'h00);
		$display("test flag clear done");
		// low byte counts falling edges of the event pin
		wrb(8'h8A, 8'h10);
		wrb(8'h89, 8'h07);
		wrb(8'h88, 8'h10);
		for (k = 0; k < 3; k++) begin
			@(posedge clk_sys) fire <= 1'b1;
			@(posedge clk_sys) fire <= 1'b0;
			repeat (10) @(posedge clk_sys);
		end
		bw(8'h8C, 1'b0);
		rdb(8'h8A); check(v, 8'h13);
		wrb(8'h89, 8'h01);
		rdb(8'h8A); check(v, 8'h13);
		$display("test event counting done");
		// gate bit set: ext input low holds the count, high frees it
		wrb(8'h89, 8'h0B);
		wrb(8'h88, 8'h10);
		repeat (20) @(posedge clk_sys);
		rdb(8'h8A); check(v, 8'h13);
		@(posedge clk_sys) gate_lvl <= 1'b1;
		repeat (10) @(posedge clk_sys);
		bw(8'h8C, 1'b0);
		// gate seen two flops late: ten enabled edges up to the stop
		rdb(8'h8A); check(v, 8'h1D);
		@(posedge clk_sys) gate_lvl <= 1'b0;
		$display("test gate done");
		// timer 1 parked in mode 3 keeps its count
		wrb(8'h8B, 8'h55);
		wrb(8'h89, 8'h33);
		wrb(8'h88, 8'h40);
		repeat (5) @(posedge clk_sys);
		bw(8'h8E, 1'b0);
		rdb(8'h8B); check(v, 8'h55);
		// timer 1 reload beside split timer 0: ticks, no flag, no pin
		wrb(8'h88, 8'h00);
		wrb(8'h8C, 8'h00);
		wrb(8'h8B, 8'hFE);
		wrb(8'h8D, 8'hFE);
		wrb(8'h89, 8'h63);
		b = bauds;
		wrb(8'h88, 8'h40);
		repeat (6) @(posedge clk_sys);
		bw(8'h8E, 1'b0);
		s = 8'hFE;
		ov = 0;
		for (k = 0; k < 8; k++) begin
			if (s == 255) begin
				s = 8'hFE;
				ov++;
			end else
				s++;
		end
		rdb(8'h8B); check(v, s[7:0]);
		rdb(8'h88); check(v, 8'h00);
		check(16'(bauds - b), 16'(ov));
		$display("test timer 1 beside split done");
		// timer 1 on its own in 16-bit mode raises its flag
		wrb(8'h89, 8'h10);
		wrb(8'h8B, 8'hFF);
		wrb(8'h8D, 8'hFF);
		wrb(8'h88, 8'h40);
		bw(8'h8E, 1'b0);
		rdb(8'h8B); check(v, 8'h01);
		rdb(8'h88); check(v, 8'h80);
		check(irq1, 1'b1);
		$display("test timer 1 flag done");
		results();
	end
endmodule
`default_nettype wire
